// ==== bench/tb_cpu_alu_instruction_subset.sv ====
// self-checking testbench for the cpu alu instruction subset
`timescale 1ns/1ps
module tb_cpu_alu_instruction_subset
    import cpualu_pkg::*;
;
    // ==========================================================
    // clock, reset and design signals
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       instrValid = 1'b0;
    cpualu_op_t instrOp = CPUALU_OP_NONE;
    logic [6:0] instrAddr = 7'h00;
    logic       instrDest = 1'b0;
    logic [7:0] instrLiteral = 8'h00;
    logic       wakeEvent = 1'b0;
    logic       instrReady, instrDone, carryFlag, digitCarryFlag, zeroFlag;
    logic       timeoutFlag, powerdownFlag, watchdogClear, prescalerClear, oscStop;
    logic [7:0] accOut, portADirection, portBDirection, portCDirection;
    int         err_total = 0;
    int         n_compared = 0;
    // bench model state
    logic [7:0] acc = 8'h00, dirA = 8'hFF, dirB = 8'hFF, dirC = 8'hFF;
    logic [7:0] mem [128];
    logic       c = 1'b0, dc = 1'b0, z = 1'b0, to = 1'b1, pd = 1'b1, sl = 1'b0;
    int         addrs [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 127};

    always #2.5 sys_clk = ~sys_clk;

    cpualu_core dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .instrValid(instrValid), .instrOp(instrOp),
        .instrAddr(instrAddr), .instrDest(instrDest), .instrLiteral(instrLiteral),
        .wakeEvent(wakeEvent), .instrReady(instrReady), .instrDone(instrDone), .accOut(accOut),
        .carryFlag(carryFlag), .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag),
        .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .portADirection(portADirection),
        .portBDirection(portBDirection), .portCDirection(portCDirection),
        .watchdogClear(watchdogClear), .prescalerClear(prescalerClear), .oscStop(oscStop)
    );

    // ==========================================================
    // compare and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string lbl);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, lbl, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("compares %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic check_all();
        check(accOut, acc, "acc");
        check({5'h0, carryFlag, digitCarryFlag, zeroFlag}, {5'h0, c, dc, z}, "flags");
        check(portADirection, dirA, "dirA");
        check(portBDirection, dirB, "dirB");
        check(portCDirection, dirC, "dirC");
        check({5'h0, timeoutFlag, powerdownFlag, oscStop}, {5'h0, to, pd, sl}, "power");
    endtask : check_all

    // ==========================================================
    // one instruction: model update, drive, wait for completion
    task automatic exec(input cpualu_op_t op, input int a, input logic d, input logic [7:0] k);
        logic [7:0] f, r;
        int         t, tn, b;
        logic       wr;
        int         n;
        f = mem[a];
        r = 8'h00;
        wr = 1'b0;
        n = 0;
        case (op)
            CPUALU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin r = {c, f[7:1]}; c = f[0]; wr = 1'b1; end
            CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL: begin
                c = acc <= k; dc = acc[3:0] <= k[3:0]; acc = k - acc; z = (acc == 8'h00);
            end
            CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER: begin
                r = f - acc; c = acc <= f; dc = acc[3:0] <= f[3:0]; z = (r == 8'h00); wr = 1'b1;
            end
            CPUALU_OP_SUBTRACT_WITH_BORROW: begin
                b = c ? 0 : 1;
                t = int'(f) - int'(acc) - b;
                tn = int'(f[3:0]) - int'(acc[3:0]) - b;
                r = 8'(t); c = (t >= 0); dc = (tn >= 0); z = (r == 8'h00); wr = 1'b1;
            end
            CPUALU_OP_NIBBLE_SWAP: begin r = {f[3:0], f[7:4]}; wr = 1'b1; end
            CPUALU_OP_DIRECTION_LOAD: begin
                if (a == 5) dirA = acc;
                if (a == 6) dirB = acc;
                if (a == 7) dirC = acc;
            end
            CPUALU_OP_XOR_LITERAL: begin acc = acc ^ k; z = (acc == 8'h00); end
            CPUALU_OP_XOR_REGISTER: begin r = acc ^ f; z = (r == 8'h00); wr = 1'b1; end
            CPUALU_OP_SLEEP: begin to = 1'b1; pd = 1'b0; sl = 1'b1; end
            default: ;
        endcase
        if (wr && d) mem[a] = r;
        if (wr && !d) acc = r;
        @(negedge sys_clk);
        instrValid = 1'b1;
        instrOp = op;
        instrAddr = a[6:0];
        instrDest = d;
        instrLiteral = k;
        @(posedge sys_clk);
        @(negedge sys_clk);
        instrValid = 1'b0;
        while (n < 6 && instrDone !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(n[7:0], 8'h01, "latency");
        check({5'h00, watchdogClear, prescalerClear, instrReady}, {5'h00, sl, sl, ~sl}, "clears");
        check_all();
    endtask : exec

    // ==========================================================
    // main sequence
    initial begin
        cpualu_op_t op;
        int         a;
        void'($urandom(32'hD1C8EC90));
        // memory has no reset: preload known random bytes into both model and design
        foreach (mem[i]) begin
            mem[i] = 8'($urandom);
            dut_u.u_file_ram.mem[i] = mem[i];
        end
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        check_all();
        foreach (addrs[i]) exec(CPUALU_OP_NIBBLE_SWAP, addrs[i], 1'b0, 8'h00);
        exec(CPUALU_OP_XOR_LITERAL, 0, 1'b0, 8'h5A);
        for (a = 4; a < 8; a++) exec(CPUALU_OP_DIRECTION_LOAD, a, 1'b0, 8'h00);
        exec(CPUALU_OP_XOR_LITERAL, 0, 1'b0, acc);
        exec(CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL, 0, 1'b0, acc);
        exec(CPUALU_OP_NONE, 3, 1'b1, 8'h33);
        for (int i = 0; i < 300; i++) begin
            op = cpualu_op_t'(4'(1 + $urandom % 8));
            exec(op, addrs[$urandom % 9], 1'($urandom % 2), 8'($urandom));
        end
        // sleep: requests are refused until wake
        exec(CPUALU_OP_SLEEP, 0, 1'b0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            instrValid = 1'b1;
            instrOp = CPUALU_OP_XOR_LITERAL;
            instrLiteral = 8'hFF;
            @(posedge sys_clk);
            #1;
            check({6'h00, instrDone, instrReady}, 8'h00, "sleep done");
        end
        @(negedge sys_clk);
        instrValid = 1'b0;
        wakeEvent = 1'b1;
        a = 0;
        while (a < 4 && oscStop !== 1'b0) begin
            @(posedge sys_clk);
            #1;
            a++;
        end
        check(a[7:0], 8'h01, "wake latency");
        check({7'h00, instrReady}, 8'h01, "wake ready");
        sl = 1'b0;
        @(negedge sys_clk);
        wakeEvent = 1'b0;
        check_all();
        exec(CPUALU_OP_XOR_REGISTER, 127, 1'b1, 8'h00);
        exec(CPUALU_OP_SUBTRACT_WITH_BORROW, 127, 1'b0, 8'h00);
        close_out();
    end

    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule : tb_cpu_alu_instruction_subset

// ==== verilog/cpualu_core.sv ====
// cpu alu executing a subset of the 8-bit instruction set
// Operation
// [RQ1] rotate right moves the addressed register one bit right through carry, old carry into bit 7.
// [RQ2] a destination bit of 0 sends the result to the accumulator, 1 back to the register.
// [RQ3] subtract from literal puts literal minus accumulator into the accumulator and updates C, DC and Z.
// [RQ4] after it carry is set when accumulator <= literal and digit carry when low nibbles compare likewise.
// [RQ5] subtract from register computes register minus accumulator, routed by the destination bit, flags updated.
// [RQ6] after it carry is set when accumulator <= register and digit carry likewise on low nibbles.
// [RQ7] subtract with borrow computes register minus accumulator minus the inverted carry, routed, flags updated.
// [RQ8] nibble swap exchanges the register nibbles, routes the result and leaves all flags alone.
// [RQ9] direction load copies the accumulator to port A, B or C direction for operand 5, 6 or 7, no flags.
// [RQ10] xor literal puts accumulator xor literal into the accumulator and updates only zero.
// [RQ11] xor register puts accumulator xor register where the destination bit says and updates only zero.
// [RQ12] sleep clears the watchdog counter and prescaler, sets the timeout flag and clears the powerdown flag.
// [RQ13] after sleep the oscillator stops and execution is suspended.
// [RQ14] an affected zero flag is set exactly when the 8-bit result is zero.
`timescale 1ns/1ps
`include "cpualu_params.svh"
module cpualu_core
    import cpualu_pkg::*;
#(
    parameter int DATA_W = `CPUALU_DATA_W,
    parameter int ADDR_W = `CPUALU_ADDR_W
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              instrValid,
    input  cpualu_op_t             instrOp,
    input  wire logic [ADDR_W-1:0] instrAddr,
    input  wire logic              instrDest,
    input  wire logic [DATA_W-1:0] instrLiteral,
    input  wire logic              wakeEvent,
    output logic                   instrReady,
    output logic                   instrDone,
    output logic      [DATA_W-1:0] accOut,
    output logic                   carryFlag,
    output logic                   digitCarryFlag,
    output logic                   zeroFlag,
    output logic                   timeoutFlag,
    output logic                   powerdownFlag,
    output logic      [DATA_W-1:0] portADirection,
    output logic      [DATA_W-1:0] portBDirection,
    output logic      [DATA_W-1:0] portCDirection,
    output logic                   watchdogClear,
    output logic                   prescalerClear,
    output logic                   oscStop
);
    // ==========================================================
    // request capture and sequencing
    cpualu_state_t     state_reg;
    cpualu_op_t        op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              dest_reg;
    logic [DATA_W-1:0] lit_reg;
    logic [DATA_W-1:0] fileData;
    logic              fileWrEn;
    logic [DATA_W-1:0] result;
    logic              resC;
    logic              resDc;
    logic              execStep;

    assign execStep = (state_reg == CPUALU_ST_READ);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= CPUALU_ST_IDLE;
        end else begin
            case (state_reg)
                CPUALU_ST_IDLE: begin
                    if (instrValid) begin
                        state_reg <= CPUALU_ST_READ;
                    end
                end
                CPUALU_ST_READ: begin
                    if (op_reg == CPUALU_OP_SLEEP) begin
                        state_reg <= CPUALU_ST_SLEEP; // RQ13
                    end else begin
                        state_reg <= CPUALU_ST_IDLE;
                    end
                end
                CPUALU_ST_SLEEP: begin
                    if (wakeEvent) begin
                        state_reg <= CPUALU_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= CPUALU_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            op_reg   <= CPUALU_OP_NONE;
            addr_reg <= '0;
            dest_reg <= 1'b0;
            lit_reg  <= '0;
        end else if (state_reg == CPUALU_ST_IDLE && instrValid) begin
            op_reg   <= instrOp;
            addr_reg <= instrAddr;
            dest_reg <= instrDest;
            lit_reg  <= instrLiteral;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            instrReady <= 1'b0;
            instrDone  <= 1'b0;
            oscStop    <= 1'b0;
        end else begin
            instrReady <= (state_reg == CPUALU_ST_IDLE && !instrValid) || (state_reg == CPUALU_ST_READ
                          && op_reg != CPUALU_OP_SLEEP) || (state_reg == CPUALU_ST_SLEEP && wakeEvent);
            instrDone  <= execStep;
            oscStop    <= (execStep && op_reg == CPUALU_OP_SLEEP)
                          || (state_reg == CPUALU_ST_SLEEP && !wakeEvent); // RQ13
        end
    end

    // ==========================================================
    // data memory
    cpualu_file_ram #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_file_ram (
        .sys_clk (sys_clk),
        .wrEn    (fileWrEn),
        .wrAddr  (addr_reg),
        .wrData  (result),
        .rdAddr  (instrAddr),
        .rdData  (fileData)
    );

    // ==========================================================
    // arithmetic
    always_comb begin
        logic [DATA_W:0] diff;
        logic [4:0]      nib;
        logic            borrow;
        diff   = '0;
        nib    = '0;
        borrow = ~carryFlag;
        result = accOut;
        resC   = carryFlag;
        resDc  = digitCarryFlag;
        case (op_reg)
            CPUALU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                result = {carryFlag, fileData[DATA_W-1:1]}; // RQ1
                resC   = fileData[0]; // RQ1
            end
            CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL: begin
                diff   = {1'b0, lit_reg} - {1'b0, accOut}; // RQ3
                nib    = {1'b0, lit_reg[3:0]} - {1'b0, accOut[3:0]};
                result = diff[DATA_W-1:0];
                resC   = ~diff[DATA_W]; // RQ4
                resDc  = ~nib[4]; // RQ4
            end
            CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER: begin
                diff   = {1'b0, fileData} - {1'b0, accOut}; // RQ5
                nib    = {1'b0, fileData[3:0]} - {1'b0, accOut[3:0]};
                result = diff[DATA_W-1:0];
                resC   = ~diff[DATA_W]; // RQ6
                resDc  = ~nib[4]; // RQ6
            end
            CPUALU_OP_SUBTRACT_WITH_BORROW: begin
                diff   = {1'b0, fileData} - {1'b0, accOut} - {{DATA_W{1'b0}}, borrow}; // RQ7
                nib    = {1'b0, fileData[3:0]} - {1'b0, accOut[3:0]} - {4'h0, borrow};
                result = diff[DATA_W-1:0];
                resC   = ~diff[DATA_W];
                resDc  = ~nib[4];
            end
            CPUALU_OP_NIBBLE_SWAP: begin
                result = {fileData[3:0], fileData[7:4]}; // RQ8
            end
            CPUALU_OP_XOR_LITERAL: begin
                result = accOut ^ lit_reg; // RQ10
            end
            CPUALU_OP_XOR_REGISTER: begin
                result = accOut ^ fileData; // RQ11
            end
            default: begin
                result = accOut;
            end
        endcase
    end

    // ==========================================================
    // destination routing
    logic toAcc;
    logic toFile;
    logic regOp;
    logic zeroOp;

    assign regOp  = (op_reg == CPUALU_OP_ROTATE_RIGHT_THROUGH_CARRY) || (op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER)
                    || (op_reg == CPUALU_OP_SUBTRACT_WITH_BORROW) || (op_reg == CPUALU_OP_NIBBLE_SWAP)
                    || (op_reg == CPUALU_OP_XOR_REGISTER);
    assign toFile = execStep && regOp && dest_reg; // RQ2
    assign toAcc  = execStep && ((regOp && !dest_reg) || (op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL)
                    || (op_reg == CPUALU_OP_XOR_LITERAL)); // RQ2
    assign fileWrEn = toFile;
    assign zeroOp = (op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL) || (op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER)
                    || (op_reg == CPUALU_OP_SUBTRACT_WITH_BORROW) || (op_reg == CPUALU_OP_XOR_LITERAL)
                    || (op_reg == CPUALU_OP_XOR_REGISTER);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accOut <= `CPUALU_ACC_RST;
        end else if (toAcc) begin
            accOut <= result;
        end
    end

    // ==========================================================
    // status flags
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            carryFlag      <= 1'b0;
            digitCarryFlag <= 1'b0;
            zeroFlag       <= 1'b0;
        end else if (execStep) begin
            if (op_reg == CPUALU_OP_ROTATE_RIGHT_THROUGH_CARRY) begin
                carryFlag <= resC;
            end else if (op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL
                         || op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER
                         || op_reg == CPUALU_OP_SUBTRACT_WITH_BORROW) begin
                carryFlag      <= resC;
                digitCarryFlag <= resDc;
            end
            if (zeroOp) begin
                zeroFlag <= (result == '0); // RQ14
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timeoutFlag    <= 1'b1;
            powerdownFlag  <= 1'b1;
            watchdogClear  <= 1'b0;
            prescalerClear <= 1'b0;
        end else begin
            watchdogClear  <= execStep && op_reg == CPUALU_OP_SLEEP; // RQ12
            prescalerClear <= execStep && op_reg == CPUALU_OP_SLEEP; // RQ12
            if (execStep && op_reg == CPUALU_OP_SLEEP) begin
                timeoutFlag   <= 1'b1; // RQ12
                powerdownFlag <= 1'b0; // RQ12
            end
        end
    end

    // ==========================================================
    // port direction registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portADirection <= `CPUALU_DIR_RST;
            portBDirection <= `CPUALU_DIR_RST;
            portCDirection <= `CPUALU_DIR_RST;
        end else if (execStep && op_reg == CPUALU_OP_DIRECTION_LOAD) begin
            if (addr_reg == `CPUALU_DIR_SEL_A) begin
                portADirection <= accOut; // RQ9
            end else if (addr_reg == `CPUALU_DIR_SEL_B) begin
                portBDirection <= accOut; // RQ9
            end else if (addr_reg == `CPUALU_DIR_SEL_C) begin
                portCDirection <= accOut; // RQ9
            end
        end
    end

    // ==========================================================
    // checks
    sequence sleepIssued;
        execStep && op_reg == CPUALU_OP_SLEEP;
    endsequence

    sequence sleepEffects;
        watchdogClear && prescalerClear && timeoutFlag && !powerdownFlag && oscStop;
    endsequence

    sleep_effects_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ12
        sleepIssued |=> sleepEffects) else $error("sleep did not clear watchdog and set flags");
    sleep_halt_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ13
        sleepIssued ##1 !wakeEvent |=> oscStop && !instrReady) else $error("sleep did not halt");
    rotate_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
        execStep && op_reg == CPUALU_OP_ROTATE_RIGHT_THROUGH_CARRY |=> carryFlag == $past(fileData[0]))
        else $error("rotate carry wrong");
    dest_acc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
        execStep && regOp && dest_reg |=> accOut == $past(accOut)) else $error("acc written for file dest");
    sublit_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ3
        execStep && op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL
        |=> accOut == 8'($past(lit_reg) - $past(accOut))) else $error("literal subtract wrong");
    sublit_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ4
        execStep && op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL
        |=> carryFlag == ($past(accOut) <= $past(lit_reg))) else $error("literal subtract carry wrong");
    subreg_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ6
        execStep && op_reg == CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER
        |=> digitCarryFlag == ($past(accOut[3:0]) <= $past(fileData[3:0]))) else $error("digit carry wrong");
    swap_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ8
        execStep && op_reg == CPUALU_OP_NIBBLE_SWAP |=> $stable(carryFlag) && $stable(zeroFlag)
        && $stable(digitCarryFlag)) else $error("swap changed flags");
    dir_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ9
        execStep && op_reg == CPUALU_OP_DIRECTION_LOAD && addr_reg == `CPUALU_DIR_SEL_B
        |=> portBDirection == $past(accOut)) else $error("port b direction not loaded");
    xor_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ14
        execStep && op_reg == CPUALU_OP_XOR_LITERAL |=> zeroFlag == (accOut == 8'h00))
        else $error("zero flag wrong");
endmodule : cpualu_core

// ==== verilog/cpualu_file_ram.sv ====
// data memory of the cpu alu with registered read data
`timescale 1ns/1ps
module cpualu_file_ram #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        rdData <= mem[rdAddr];
    end
endmodule : cpualu_file_ram

// ==== verilog/cpualu_params.svh ====
// constants for the cpu alu instruction subset
`ifndef CPUALU_PARAMS_SVH
`define CPUALU_PARAMS_SVH
`define CPUALU_DATA_W      8
`define CPUALU_ADDR_W      7
`define CPUALU_ACC_RST     8'h00
`define CPUALU_DIR_RST     8'hFF
`define CPUALU_DIR_SEL_A   7'h05
`define CPUALU_DIR_SEL_B   7'h06
`define CPUALU_DIR_SEL_C   7'h07
`define CPUALU_WDOG_CLR    8'h00
`define CPUALU_PRESC_CLR   8'h00
`endif

// ==== verilog/cpualu_pkg.sv ====
// types for the cpu alu instruction subset
package cpualu_pkg;
    typedef enum logic [3:0] {
        CPUALU_OP_NONE,
        CPUALU_OP_ROTATE_RIGHT_THROUGH_CARRY,
        CPUALU_OP_SUBTRACT_ACC_FROM_LITERAL,
        CPUALU_OP_SUBTRACT_ACC_FROM_REGISTER,
        CPUALU_OP_SUBTRACT_WITH_BORROW,
        CPUALU_OP_NIBBLE_SWAP,
        CPUALU_OP_DIRECTION_LOAD,
        CPUALU_OP_XOR_LITERAL,
        CPUALU_OP_XOR_REGISTER,
        CPUALU_OP_SLEEP
    } cpualu_op_t;
    typedef enum logic [1:0] {
        CPUALU_ST_IDLE,
        CPUALU_ST_READ,
        CPUALU_ST_SLEEP
    } cpualu_state_t;
endpackage : cpualu_pkg
